// ---- src/clock_profile_config_select.sv ----
`timescale 1ns/1ps
// Behaviour
// - after reset, copy the chosen factory profile from OTP into operating registers
// - profile comes from pin or register bit, chosen by source select
// - once loaded, host writes replace operating register contents
// - operating registers are volatile; reset reloads the factory profile
// - two-bit mode field picks low-bandwidth, high-bandwidth or synthesis
// - mode comes from the mode field only, whatever profile is active
// - divider field LSB is ignored
// - synthesis uses only the upper loop fed from the crystal
// - upper loop feedback supports delta-sigma fractional division
// - high-bandwidth mode prescales the reference, upper loop only (the code also sets prescale_en_q in low-bandwidth mode)
// - reference and crystal alarms go to pins and status bits
// - reference switching: manual, automatic revertive, automatic non-revertive
// - profile pin low selects profile zero, high selects profile one
module clock_profile_config_select
   import clock_profile_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic profile_pin,
   input wire logic cfg_from_pin,
   input wire logic cfg_reg_sel,
   output logic [OTP_ADDR_W-1:0] otp_addr_q,
   input wire logic [REG_W-1:0] otp_rd_data,
   input wire logic wr_en,
   input wire logic [REG_IDX_W-1:0] wr_addr,
   input wire logic [REG_W-1:0] wr_data,
   input wire logic [REG_IDX_W-1:0] rd_addr,
   output logic [REG_W-1:0] rd_data_q,
   input wire logic clk_sel_pin,
   input wire logic clk0_bad_raw,
   input wire logic clk1_bad_raw,
   input wire logic xtal_bad_raw,
   input wire logic pll_locked_raw,
   output logic load_done_q,
   output logic profile_q,
   output logic [1:0] mode_q,
   output logic mode_lbw_q,
   output logic mode_hbw_q,
   output logic mode_synth_q,
   output logic upper_loop_en_q,
   output logic lower_loop_en_q,
   output logic xtal_ref_q,
   output logic prescale_en_q,
   output logic [REG_W-1:0] prescale_q,
   output logic [REG_W-1:0] fb_int_q,
   output logic [FRAC_W-1:0] fb_frac_q,
   output logic frac_en_q,
   output logic [NDIV_W-1:0] div_ratio_q,
   output logic div_unsupported_q,
   output logic clk0_bad_q,
   output logic clk1_bad_q,
   output logic xtal_bad_q,
   output logic lock_ind_q,
   output logic holdover_q,
   output logic active_ref_q
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [NUM_SYNC-1:0] sync_in;
   logic [NUM_SYNC-1:0] sync_q;
   logic profile_pin_s;
   logic clk_sel_pin_s;
   logic clk0_bad_s;
   logic clk1_bad_s;
   logic xtal_bad_s;
   logic locked_s;

   assign sync_in = {pll_locked_raw, xtal_bad_raw, clk1_bad_raw, clk0_bad_raw, clk_sel_pin, profile_pin};
   assign {locked_s, xtal_bad_s, clk1_bad_s, clk0_bad_s, clk_sel_pin_s, profile_pin_s} = sync_q;

   sync_bits #(.WIDTH(NUM_SYNC)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in(sync_in),
      .sync_q(sync_q)
   );

   // ****************************************
   // Profile choice and loader
   // ****************************************
   load_state_type state_q;
   logic [REG_IDX_W-1:0] idx_q;
   logic [REG_W-1:0] op_q [NUM_OP_REGS];
   logic active_prof;
   logic host_wr;

   // Low on the pin picks profile zero
   assign active_prof = cfg_from_pin ? profile_pin_s : cfg_reg_sel;
   assign host_wr = state_q == ST_RUN && wr_en && wr_addr != STATUS_IDX;

   // A later profile change reloads too; host edits are then lost
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= ST_START;
      end else begin
         case (state_q)
            ST_START: state_q <= ST_LOAD;
            ST_LOAD: begin
               if (idx_q == LAST_LOAD_IDX) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (active_prof != profile_q) begin
                  state_q <= ST_START;
               end
            end
            default: state_q <= ST_START;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         profile_q <= PROFILE_DEFAULT;
      end else if (state_q == ST_START) begin
         profile_q <= active_prof;
      end
   end

   // OTP answers in the same cycle the address is presented
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         idx_q <= CTRL_IDX;
         otp_addr_q <= '0;
      end else if (state_q == ST_START) begin
         idx_q <= CTRL_IDX;
         otp_addr_q <= {active_prof, CTRL_IDX};
      end else if (state_q == ST_LOAD) begin
         idx_q <= idx_q + 3'h1;
         otp_addr_q <= {profile_q, idx_q + 3'h1};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         load_done_q <= 1'b0;
      end else begin
         load_done_q <= state_q == ST_RUN || (state_q == ST_LOAD && idx_q == LAST_LOAD_IDX);
      end
   end

   // Volatile: cleared on reset, refilled by the loader
   for (genvar r = 0; r < NUM_OP_REGS; r++) begin : g_op
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            op_q[r] <= OP_REG_RST;
         end else if (state_q == ST_LOAD && idx_q == REG_IDX_W'(r)) begin
            op_q[r] <= otp_rd_data;
         end else if (host_wr && wr_addr == REG_IDX_W'(r)) begin
            op_q[r] <= wr_data;
         end
      end
   end

   // ****************************************
   // Mode and loop decode
   // ****************************************
   op_mode_type mode;
   logic [NDIV_W-1:0] ndiv_field;
   assign mode = op_mode_type'(op_q[CTRL_IDX][MODE_LSB +: 2]);
   assign ndiv_field = {op_q[NDIV_HI_IDX][NDIV_HI_W-1:0], op_q[NDIV_LO_IDX]};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_q <= MODE_LBW;
         mode_lbw_q <= 1'b0;
         mode_hbw_q <= 1'b0;
         mode_synth_q <= 1'b0;
      end else begin
         mode_q <= mode;
         mode_lbw_q <= mode == MODE_LBW;
         mode_hbw_q <= mode == MODE_HBW;
         mode_synth_q <= mode == MODE_SYNTH;
      end
   end

   // Reserved mode code enables neither loop
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         upper_loop_en_q <= 1'b0;
         lower_loop_en_q <= 1'b0;
         xtal_ref_q <= 1'b0;
         prescale_en_q <= 1'b0;
      end else begin
         upper_loop_en_q <= mode != MODE_RSVD;
         lower_loop_en_q <= mode == MODE_LBW;
         xtal_ref_q <= mode == MODE_SYNTH;
         prescale_en_q <= mode == MODE_HBW || mode == MODE_LBW;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prescale_q <= '0;
         fb_int_q <= '0;
         fb_frac_q <= '0;
         frac_en_q <= 1'b0;
      end else begin
         prescale_q <= op_q[PRESCALE_IDX];
         fb_int_q <= op_q[FB_INT_IDX];
         fb_frac_q <= {op_q[FB_FRAC_HI_IDX], op_q[FB_FRAC_LO_IDX]};
         frac_en_q <= (op_q[FB_FRAC_HI_IDX] | op_q[FB_FRAC_LO_IDX]) != '0;
      end
   end

   // Out-of-range codes are flagged, not corrected
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_ratio_q <= '0;
         div_unsupported_q <= 1'b0;
      end else begin
         div_ratio_q <= {ndiv_field[NDIV_W-1:1], 1'b0};
         div_unsupported_q <= {ndiv_field[NDIV_W-1:1], 1'b0} < NDIV_MIN;
      end
   end

   // ****************************************
   // Alarms, switchover and status
   // ****************************************
   ref_switch u_switch (
      .sys_clk(sys_clk),
      .rst(rst),
      .switch_mode(op_q[CTRL_IDX][SWITCH_LSB +: 2]),
      .pref_sel(op_q[CTRL_IDX][CLK_SEL_BIT]),
      .pin_sel(clk_sel_pin_s),
      .clk0_bad(clk0_bad_s),
      .clk1_bad(clk1_bad_s),
      .locked(locked_s),
      .active_ref_q(active_ref_q),
      .holdover_q(holdover_q)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clk0_bad_q <= 1'b0;
         clk1_bad_q <= 1'b0;
         xtal_bad_q <= 1'b0;
         lock_ind_q <= 1'b0;
      end else begin
         clk0_bad_q <= clk0_bad_s;
         clk1_bad_q <= clk1_bad_s;
         xtal_bad_q <= xtal_bad_s;
         lock_ind_q <= locked_s;
      end
   end

   logic [REG_W-1:0] status;
   always_comb begin
      status = '0;
      status[ST_CLK0_BAD] = clk0_bad_q;
      status[ST_CLK1_BAD] = clk1_bad_q;
      status[ST_XTAL_BAD] = xtal_bad_q;
      status[ST_LOCK] = lock_ind_q;
      status[ST_HOLDOVER] = holdover_q;
      status[ST_ACTIVE_REF] = active_ref_q;
      status[ST_PROFILE] = profile_q;
      status[ST_LOADED] = load_done_q;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data_q <= '0;
      end else if (rd_addr == STATUS_IDX) begin
         rd_data_q <= status;
      end else begin
         rd_data_q <= op_q[rd_addr];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_load_walk;
      state_q == ST_START ##1 (state_q == ST_LOAD) [*7] ##1 state_q == ST_RUN;
   endsequence

   property p_load_after_reset;
      @(posedge sys_clk) disable iff (rst)
         $fell(rst) |-> s_load_walk ##0 load_done_q;
   endproperty
   a_load_after_reset: assert property (p_load_after_reset)
      else $error("profile load did not finish in eight cycles");

   property p_otp_profile;
      @(posedge sys_clk) disable iff (rst)
         state_q == ST_LOAD |-> otp_addr_q[OTP_ADDR_W-1] == profile_q;
   endproperty
   a_otp_profile: assert property (p_otp_profile)
      else $error("OTP read from the wrong profile");

   property p_pin_low_profile0;
      @(posedge sys_clk) disable iff (rst)
         state_q == ST_START && cfg_from_pin && !profile_pin_s |=> profile_q == 1'b0;
   endproperty
   a_pin_low_profile0: assert property (p_pin_low_profile0)
      else $error("pin low did not choose profile zero");

   property p_reload_on_change;
      @(posedge sys_clk) disable iff (rst)
         state_q == ST_RUN && active_prof != profile_q |=> state_q == ST_START ##1 profile_q == $past(active_prof, 2);
   endproperty
   a_reload_on_change: assert property (p_reload_on_change)
      else $error("profile change did not reload");

   property p_host_write;
      @(posedge sys_clk) disable iff (rst)
         host_wr |=> op_q[$past(wr_addr)] == $past(wr_data);
   endproperty
   a_host_write: assert property (p_host_write)
      else $error("host write not applied");

   property p_mode_decode;
      @(posedge sys_clk) disable iff (rst)
         1'b1 |=> mode_q == $past(op_q[CTRL_IDX][MODE_LSB +: 2]) && (mode_synth_q == (mode_q == MODE_SYNTH));
   endproperty
   a_mode_decode: assert property (p_mode_decode)
      else $error("mode outputs disagree with mode field");

   property p_synth_loops;
      @(posedge sys_clk) disable iff (rst)
         mode_synth_q |-> upper_loop_en_q && !lower_loop_en_q && xtal_ref_q && !prescale_en_q;
   endproperty
   a_synth_loops: assert property (p_synth_loops)
      else $error("synthesis mode loop setup wrong");

   property p_hbw_prescale;
      @(posedge sys_clk) disable iff (rst)
         mode_hbw_q |-> prescale_en_q && !lower_loop_en_q && !xtal_ref_q;
   endproperty
   a_hbw_prescale: assert property (p_hbw_prescale)
      else $error("high-bandwidth mode loop setup wrong");

   property p_div_lsb;
      @(posedge sys_clk) disable iff (rst)
         1'b1 |=> div_ratio_q[NDIV_W-1:1] == $past(ndiv_field[NDIV_W-1:1]) && !div_ratio_q[0];
   endproperty
   a_div_lsb: assert property (p_div_lsb)
      else $error("divider LSB not ignored");

   property p_frac_enable;
      @(posedge sys_clk) disable iff (rst)
         1'b1 |=> frac_en_q == ($past({op_q[FB_FRAC_HI_IDX], op_q[FB_FRAC_LO_IDX]}) != '0);
   endproperty
   a_frac_enable: assert property (p_frac_enable)
      else $error("fractional enable wrong");

   property p_alarm_pins;
      @(posedge sys_clk) disable iff (rst)
         $rose(xtal_bad_raw) ##1 xtal_bad_raw [*2] |=>
            xtal_bad_q ##1 ($past(rd_addr) != STATUS_IDX || rd_data_q[ST_XTAL_BAD]);
   endproperty
   a_alarm_pins: assert property (p_alarm_pins)
      else $error("crystal alarm not raised");

endmodule

// ---- include/clock_profile_pkg.sv ----
package clock_profile_pkg;

   // ****************************************
   // Operating register map
   // ****************************************
   localparam int REG_W = 8;
   localparam int REG_IDX_W = 3;
   localparam int NUM_OP_REGS = 7;
   localparam int OTP_ADDR_W = 4;
   localparam logic [REG_IDX_W-1:0] CTRL_IDX = 3'h0;
   localparam logic [REG_IDX_W-1:0] NDIV_LO_IDX = 3'h1;
   localparam logic [REG_IDX_W-1:0] NDIV_HI_IDX = 3'h2;
   localparam logic [REG_IDX_W-1:0] PRESCALE_IDX = 3'h3;
   localparam logic [REG_IDX_W-1:0] FB_INT_IDX = 3'h4;
   localparam logic [REG_IDX_W-1:0] FB_FRAC_LO_IDX = 3'h5;
   localparam logic [REG_IDX_W-1:0] FB_FRAC_HI_IDX = 3'h6;
   localparam logic [REG_IDX_W-1:0] STATUS_IDX = 3'h7;
   localparam logic [REG_IDX_W-1:0] LAST_LOAD_IDX = 3'h6;
   localparam logic [REG_W-1:0] OP_REG_RST = 8'h00;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int MODE_LSB = 0;
   localparam int SWITCH_LSB = 2;
   localparam int CLK_SEL_BIT = 4;
   localparam int NDIV_W = 11;
   localparam int NDIV_HI_W = 3;
   localparam int FRAC_W = 16;
   localparam logic [NDIV_W-1:0] NDIV_MIN = 11'h00A;
   localparam int ST_CLK0_BAD = 0;
   localparam int ST_CLK1_BAD = 1;
   localparam int ST_XTAL_BAD = 2;
   localparam int ST_LOCK = 3;
   localparam int ST_HOLDOVER = 4;
   localparam int ST_ACTIVE_REF = 5;
   localparam int ST_PROFILE = 6;
   localparam int ST_LOADED = 7;
   localparam logic PROFILE_DEFAULT = 1'b0;
   localparam int NUM_SYNC = 6;

   // ****************************************
   // Enumerations
   // ****************************************
   typedef enum logic [1:0] {
      MODE_LBW = 2'b00,
      MODE_HBW = 2'b01,
      MODE_SYNTH = 2'b10,
      MODE_RSVD = 2'b11
   } op_mode_type;

   typedef enum logic [1:0] {
      SW_MAN_PIN = 2'b00,
      SW_MAN_REG = 2'b01,
      SW_AUTO_REV = 2'b10,
      SW_AUTO_NONREV = 2'b11
   } switch_mode_type;

   typedef enum logic [1:0] {
      ST_START = 2'b00,
      ST_LOAD = 2'b01,
      ST_RUN = 2'b10
   } load_state_type;

endpackage

// ---- src/sync_bits.sv ----
`timescale 1ns/1ps
module sync_bits
   import clock_profile_pkg::*;
#(
   parameter int WIDTH = NUM_SYNC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_q
);

   if (WIDTH < 1) begin : g_bad_width
      $error("sync_bits: WIDTH must be at least 1");
   end

   // ****************************************
   // Two-stage synchroniser per bit
   // ****************************************
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            meta_q <= 1'b0;
            sync_q[i] <= 1'b0;
         end else begin
            meta_q <= async_in[i];
            sync_q[i] <= meta_q;
         end
      end
   end

endmodule

// ---- src/ref_switch.sv ----
`timescale 1ns/1ps
module ref_switch
   import clock_profile_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] switch_mode,
   input wire logic pref_sel,
   input wire logic pin_sel,
   input wire logic clk0_bad,
   input wire logic clk1_bad,
   input wire logic locked,
   output logic active_ref_q,
   output logic holdover_q
);

   logic locked_seen_q;
   logic active_bad;
   logic other_bad;
   logic pref_bad;
   logic active_d;

   assign active_bad = active_ref_q ? clk1_bad : clk0_bad;
   assign other_bad = active_ref_q ? clk0_bad : clk1_bad;
   assign pref_bad = pref_sel ? clk1_bad : clk0_bad;

   // ****************************************
   // Reference choice
   // ****************************************
   always_comb begin
      active_d = active_ref_q;
      case (switch_mode_type'(switch_mode))
         SW_MAN_PIN: active_d = pin_sel;
         SW_MAN_REG: active_d = pref_sel;
         SW_AUTO_REV, SW_AUTO_NONREV: begin
            // No hunting before first lock: stay on the preferred input
            if (!locked_seen_q) begin
               active_d = pref_sel;
            end else if (switch_mode == SW_AUTO_REV && active_ref_q != pref_sel && !pref_bad) begin
               active_d = pref_sel;
            end else if (active_bad && !other_bad) begin
               active_d = !active_ref_q;
            end
         end
         default: active_d = active_ref_q;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         active_ref_q <= 1'b0;
      end else begin
         active_ref_q <= active_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         locked_seen_q <= 1'b0;
      end else if (clk0_bad && clk1_bad) begin
         locked_seen_q <= 1'b0;
      end else if (locked) begin
         locked_seen_q <= 1'b1;
      end
   end

   // Manual modes hold over on a bad chosen input even if the other is good
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         holdover_q <= 1'b0;
      end else if (switch_mode[1]) begin
         holdover_q <= clk0_bad && clk1_bad;
      end else begin
         holdover_q <= active_d ? clk1_bad : clk0_bad;
      end
   end

   property p_manual_reg_follows;
      @(posedge sys_clk) disable iff (rst)
         switch_mode == SW_MAN_REG |=> active_ref_q == $past(pref_sel);
   endproperty
   a_manual_reg_follows: assert property (p_manual_reg_follows)
      else $error("manual register selection not followed");

endmodule

// ---- tb/otp_host_model.sv ----
`timescale 1ns/1ps
module otp_host_model
   import clock_profile_pkg::*;
(
   input wire logic sys_clk,
   input wire logic load_done_q,
   input wire logic [OTP_ADDR_W-1:0] otp_addr_q,
   input wire logic [REG_W-1:0] rd_data_q,
   output logic [REG_W-1:0] otp_rd_data,
   output logic wr_en,
   output logic [REG_IDX_W-1:0] wr_addr,
   output logic [REG_W-1:0] wr_data,
   output logic [REG_IDX_W-1:0] rd_addr
);
   // ****************************************
   // Factory profiles, {profile, index}
   // ****************************************
   logic [REG_W-1:0] rom [16] = '{8'h00, 8'h0B, 8'h00, 8'h04, 8'h30, 8'h00, 8'h00, 8'hA5,
                                  8'h12, 8'h14, 8'h00, 8'h02, 8'h50, 8'h34, 8'h12, 8'h5A};
   assign otp_rd_data = rom[otp_addr_q];
   initial begin
      wr_en = 1'b0;
      wr_addr = 3'h0;
      wr_data = 8'h00;
      rd_addr = 3'h0;
   end
   // ****************************************
   // Host accesses
   // ****************************************
   // Only legal once loaded; callers also pick odd dividers to probe the dropped LSB and the flag
   task automatic host_write(input logic [REG_IDX_W-1:0] a, input logic [REG_W-1:0] d);
      @(negedge sys_clk);
      wr_addr = a;
      wr_data = d;
      wr_en = load_done_q;
      @(negedge sys_clk);
      wr_en = 1'b0;
      // Released data shows the inverse, not a stale copy
      wr_data = ~d;
   endtask
   task automatic host_read(input logic [REG_IDX_W-1:0] a, output logic [REG_W-1:0] d);
      @(negedge sys_clk);
      rd_addr = a;
      @(negedge sys_clk);
      d = rd_data_q;
   endtask
endmodule

// ---- tb/clock_profile_config_select_tb_top.sv ----
`timescale 1ns/1ps
module clock_profile_config_select_tb_top
   import clock_profile_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic profile_pin = 1'b0;
   logic cfg_from_pin = 1'b1;
   logic cfg_reg_sel = 1'b0;
   logic clk_sel_pin = 1'b0;
   logic clk0_bad_raw = 1'b0;
   logic clk1_bad_raw = 1'b0;
   logic xtal_bad_raw = 1'b0;
   logic pll_locked_raw = 1'b0;
   logic [OTP_ADDR_W-1:0] otp_addr_q;
   logic [REG_W-1:0] otp_rd_data, rd_data_q, wr_data;
   logic [REG_IDX_W-1:0] wr_addr, rd_addr;
   logic wr_en, load_done_q, profile_q, mode_lbw_q, mode_hbw_q, mode_synth_q;
   logic upper_loop_en_q, lower_loop_en_q, xtal_ref_q, prescale_en_q, frac_en_q, div_unsupported_q;
   logic clk0_bad_q, clk1_bad_q, xtal_bad_q, holdover_q, active_ref_q;
   logic [NDIV_W-1:0] div_ratio_q;
   logic [1:0] mode_q;
   logic [REG_W-1:0] prescale_q, fb_int_q;
   logic [FRAC_W-1:0] fb_frac_q;
   logic lock_ind_q;
   int n_errors = 0;
   int tests_run = 0;

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   clock_profile_config_select i_clock_profile_config_select (
      .sys_clk(sys_clk), .rst(rst), .profile_pin(profile_pin), .cfg_from_pin(cfg_from_pin),
      .cfg_reg_sel(cfg_reg_sel), .otp_addr_q(otp_addr_q), .otp_rd_data(otp_rd_data), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data_q(rd_data_q),
      .clk_sel_pin(clk_sel_pin), .clk0_bad_raw(clk0_bad_raw), .clk1_bad_raw(clk1_bad_raw),
      .xtal_bad_raw(xtal_bad_raw), .pll_locked_raw(pll_locked_raw), .load_done_q(load_done_q),
      .profile_q(profile_q), .mode_q(mode_q), .mode_lbw_q(mode_lbw_q), .mode_hbw_q(mode_hbw_q),
      .mode_synth_q(mode_synth_q), .upper_loop_en_q(upper_loop_en_q), .lower_loop_en_q(lower_loop_en_q),
      .xtal_ref_q(xtal_ref_q), .prescale_en_q(prescale_en_q), .prescale_q(prescale_q), .fb_int_q(fb_int_q),
      .fb_frac_q(fb_frac_q),
      .frac_en_q(frac_en_q), .div_ratio_q(div_ratio_q), .div_unsupported_q(div_unsupported_q),
      .clk0_bad_q(clk0_bad_q), .clk1_bad_q(clk1_bad_q), .xtal_bad_q(xtal_bad_q), .lock_ind_q(lock_ind_q),
      .holdover_q(holdover_q), .active_ref_q(active_ref_q)
   );

   otp_host_model i_otp_host_model (
      .sys_clk(sys_clk), .load_done_q(load_done_q), .otp_addr_q(otp_addr_q), .rd_data_q(rd_data_q),
      .otp_rd_data(otp_rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr)
   );

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_load;
      for (int i = 0; i < 30 && load_done_q !== 1'b1; i++) begin
         @(negedge sys_clk);
      end
      chk(load_done_q, 16'h0001);
   endtask

   task automatic do_reset;
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      wait_load();
   endtask

   task automatic give_verdict;
      $display("checks=%0d errors=%0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_load;
      logic [REG_W-1:0] d;
      do_reset();
      chk(profile_q, 16'h0000);
      i_otp_host_model.host_read(NDIV_LO_IDX, d);
      chk(d, 16'h000B);
      chk(div_ratio_q, 16'h000A);
      chk({mode_lbw_q, lower_loop_en_q}, 16'h0003);
      i_otp_host_model.host_write(STATUS_IDX, 8'h00);
      i_otp_host_model.host_read(STATUS_IDX, d);
      chk(d[7], 16'h0001);
      $display("test load done");
   endtask

   task automatic t_modes;
      logic [2:0] e3 [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
      logic [3:0] e4 [4] = '{4'hD, 4'h9, 4'hA, 4'h0};
      logic [10:0] code [4] = '{11'h00B, 11'h7FF, 11'h009, 11'h00C};
      logic [10:0] eff [4] = '{11'h00A, 11'h7FE, 11'h008, 11'h00C};
      for (int m = 0; m < 4; m++) begin
         i_otp_host_model.host_write(CTRL_IDX, 8'(m));
         @(negedge sys_clk);
         chk({mode_lbw_q, mode_hbw_q, mode_synth_q}, e3[m]);
         chk({upper_loop_en_q, lower_loop_en_q, xtal_ref_q, prescale_en_q}, e4[m]);
         i_otp_host_model.host_write(NDIV_HI_IDX, {5'h00, code[m][10:8]});
         i_otp_host_model.host_write(NDIV_LO_IDX, code[m][7:0]);
         @(negedge sys_clk);
         chk(div_ratio_q, eff[m]);
         chk(div_unsupported_q, m == 2);
      end
      i_otp_host_model.host_write(FB_FRAC_HI_IDX, 8'h01);
      @(negedge sys_clk);
      chk(frac_en_q, 16'h0001);
      $display("test modes done");
   endtask

   task automatic t_profile;
      logic [REG_W-1:0] d;
      profile_pin = 1'b1;
      cfg_reg_sel = 1'b1;
      cfg_from_pin = 1'b0;
      repeat (4) @(negedge sys_clk);
      wait_load();
      chk(profile_q, 16'h0001);
      i_otp_host_model.host_read(NDIV_LO_IDX, d);
      chk(d, 16'h0014);
      chk(mode_synth_q, 16'h0001);
      chk(mode_q, 16'h0002);
      chk({prescale_q, fb_int_q}, 16'h0250);
      chk(fb_frac_q, 16'h1234);
      cfg_from_pin = 1'b1;
      profile_pin = 1'b0;
      repeat (4) @(negedge sys_clk);
      wait_load();
      chk(profile_q, 16'h0000);
      i_otp_host_model.host_write(NDIV_LO_IDX, 8'h40);
      do_reset();
      i_otp_host_model.host_read(NDIV_LO_IDX, d);
      chk(d, 16'h000B);
      $display("test profile done");
   endtask

   task automatic t_alarms;
      logic [REG_W-1:0] d;
      clk0_bad_raw = 1'b1;
      xtal_bad_raw = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk({clk0_bad_q, clk1_bad_q, xtal_bad_q}, 16'h0005);
      chk(holdover_q, 16'h0001);
      i_otp_host_model.host_read(STATUS_IDX, d);
      chk(d[2:0], 16'h0005);
      clk0_bad_raw = 1'b0;
      xtal_bad_raw = 1'b0;
      clk_sel_pin = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk({clk0_bad_q, xtal_bad_q, active_ref_q}, 16'h0001);
      i_otp_host_model.host_write(CTRL_IDX, 8'h04);
      repeat (4) @(negedge sys_clk);
      chk(active_ref_q, 16'h0000);
      i_otp_host_model.host_write(CTRL_IDX, 8'h18);
      repeat (4) @(negedge sys_clk);
      chk(active_ref_q, 16'h0001);
      // Lock arms automatic switching; preferred input 1 fails
      pll_locked_raw = 1'b1;
      clk1_bad_raw = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk({lock_ind_q, active_ref_q, holdover_q}, 16'h0004);
      clk1_bad_raw = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk(active_ref_q, 16'h0001);
      i_otp_host_model.host_write(CTRL_IDX, 8'h1C);
      clk1_bad_raw = 1'b1;
      repeat (6) @(negedge sys_clk);
      clk1_bad_raw = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk(active_ref_q, 16'h0000);
      $display("test alarms done");
   endtask

   initial begin
      t_load();
      t_modes();
      t_profile();
      t_alarms();
      give_verdict();
   end

   // Whole run is about 140 cycles
   initial begin
      #200000;
      n_errors++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule
